//--- pkg/sdhts_regs.vh
`ifndef SDHTS_REGS_VH
`define SDHTS_REGS_VH

// ----------------------------------------------------------------------
// byte classes on the rx and tx kind buses
// ----------------------------------------------------------------------
`define SDHTS_KIND_PAYLOAD 4'h0
`define SDHTS_KIND_RSOH 4'h1
`define SDHTS_KIND_MSOH 4'h2
`define SDHTS_KIND_K2 4'h3
`define SDHTS_KIND_H1 4'h4
`define SDHTS_KIND_H2 4'h5
`define SDHTS_KIND_POH 4'h6
`define SDHTS_KIND_LABEL 4'h7
`define SDHTS_KIND_BIP 4'h8
`define SDHTS_KIND_TRIB 4'h9
`define SDHTS_KIND_JUST 4'ha
`define SDHTS_KIND_REMOTE 4'hb

// ----------------------------------------------------------------------
// source alarm layer modes
// ----------------------------------------------------------------------
`define SDHTS_MODE_MS 3'h0
`define SDHTS_MODE_AU 3'h1
`define SDHTS_MODE_TU 3'h2
`define SDHTS_MODE_PDH_LINE 3'h3
`define SDHTS_MODE_PDH_TRIB 3'h4

// ----------------------------------------------------------------------
// label codes, patterns, field positions
// ----------------------------------------------------------------------
`define SDHTS_LABEL_UNEQUIPPED 8'h00
`define SDHTS_LABEL_NON_SPECIFIC 8'h01
`define SDHTS_ALL_ONES 8'hff
`define SDHTS_K2_AIS_MSB 2
`define SDHTS_K2_AIS_LSB 0
`define SDHTS_K2_AIS_CODE 3'h7
`define SDHTS_REMOTE_REI_MSB 7
`define SDHTS_REMOTE_REI_LSB 4
`define SDHTS_REMOTE_RDI_BIT 3

// ----------------------------------------------------------------------
// persistence counts, in frames
// ----------------------------------------------------------------------
`define SDHTS_LABEL_ACCEPT_FRAMES 3'h5
`define SDHTS_AIS_PERSIST_FRAMES 3'h3

`endif

//--- core/sdhts_trail_supervision.v
`timescale 1ns/10ps
`default_nettype none
`include "sdhts_regs.vh"

module sdhts_trail_supervision #(
    parameter REI_WIDTH = 4,
    parameter ERR_COUNT_WIDTH = 16
) (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] rxData,
    input wire rxValid,
    input wire rxFrameStart,
    input wire [3:0] rxKind,
    input wire frameLossDefect,
    input wire pointerLossDefect,
    input wire [7:0] expectedLabel,
    input wire [7:0] txData,
    input wire txValid,
    input wire [3:0] txKind,
    input wire txAllOnesIn,
    input wire txServerFailIn,
    input wire [2:0] txLayerMode,
    input wire [7:0] transmittedLabel,
    output reg [7:0] rxDataOut_r,
    output reg rxValidOut_r,
    output reg serverFailIndication_r,
    output reg msAisDefect_r,
    output reg auAlarmDefect_r,
    output reg [7:0] acceptedLabel_r,
    output reg labelMismatch_r,
    output reg labelUnequipped_r,
    output reg bitErrorPulse_r,
    output reg [ERR_COUNT_WIDTH-1:0] bitErrorCount_r,
    output reg farEndReceiveFailureBits_r,
    output reg [REI_WIDTH-1:0] farEndBlockErrorBits_r,
    output reg tandemUnavailable_r,
    output reg [7:0] txDataOut_r,
    output reg txValidOut_r
);

// ----------------------------------------------------------------------
// functions
// ----------------------------------------------------------------------
function [3:0] popCount;
    input [7:0] v;
    integer i;
    begin
        popCount = 4'h0;
        for (i = 0; i < 8; i = i + 1)
            popCount = popCount + {3'h0, v[i]};
    end
endfunction

// frame counter toward flipping a persistent defect state
function [2:0] persistNext;
    input [2:0] cnt;
    input seen;
    input state;
    begin
        if (seen == state)
            persistNext = 3'h0;
        else if (cnt == `SDHTS_AIS_PERSIST_FRAMES - 3'h1)
            persistNext = 3'h0;
        else
            persistNext = cnt + 3'h1;
    end
endfunction

// ----------------------------------------------------------------------
// sink state
// ----------------------------------------------------------------------
reg [7:0] bipAcc_r;
reg [7:0] bipPrev_r;
reg [7:0] labelCand_r;
reg [2:0] labelCnt_r;
reg [2:0] k2Cnt_r;
reg [2:0] auCnt_r;
reg h1Ones_r;
reg [7:0] mismatchBits;
reg [3:0] errBits;
reg [ERR_COUNT_WIDTH-1:0] errSum;
reg k2Seen;
reg auSeen;
reg sinkDefect;
reg labelMatch;

always @*
begin
    mismatchBits = rxData ^ bipPrev_r;
    errBits = popCount(mismatchBits);
    errSum = bitErrorCount_r + {{(ERR_COUNT_WIDTH-4){1'b0}}, errBits};
    k2Seen = (rxData[`SDHTS_K2_AIS_MSB:`SDHTS_K2_AIS_LSB] == `SDHTS_K2_AIS_CODE);
    auSeen = h1Ones_r && (rxData == `SDHTS_ALL_ONES);
    sinkDefect = frameLossDefect || msAisDefect_r || auAlarmDefect_r;
    labelMatch = (acceptedLabel_r == expectedLabel) ||
        ((acceptedLabel_r == `SDHTS_LABEL_NON_SPECIFIC) &&
         (expectedLabel != `SDHTS_LABEL_UNEQUIPPED));
end

// ----------------------------------------------------------------------
// parity check and error count
// ----------------------------------------------------------------------
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        bipAcc_r <= 8'h00;
        bipPrev_r <= 8'h00;
        bitErrorPulse_r <= 1'b0;
        bitErrorCount_r <= {ERR_COUNT_WIDTH{1'b0}};
        farEndBlockErrorBits_r <= {REI_WIDTH{1'b0}};
    end
    else
    begin
        bitErrorPulse_r <= 1'b0;
        if (rxValid)
        begin
            if (rxFrameStart)
            begin
                bipPrev_r <= bipAcc_r;
                bipAcc_r <= rxData;
            end
            else if (rxKind != `SDHTS_KIND_BIP)
                bipAcc_r <= bipAcc_r ^ rxData;
            if (rxKind == `SDHTS_KIND_BIP && !rxFrameStart)
            begin
                bitErrorPulse_r <= (errBits != 4'h0);
                if (errSum >= bitErrorCount_r)
                    bitErrorCount_r <= errSum;
                else
                    bitErrorCount_r <= {ERR_COUNT_WIDTH{1'b1}};
                if (errBits > {REI_WIDTH{1'b1}})
                    farEndBlockErrorBits_r <= {REI_WIDTH{1'b1}};
                else
                    farEndBlockErrorBits_r <= errBits[REI_WIDTH-1:0];
            end
        end
    end
end

// ----------------------------------------------------------------------
// label acceptance and comparison
// ----------------------------------------------------------------------
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        labelCand_r <= 8'h00;
        labelCnt_r <= 3'h0;
        acceptedLabel_r <= `SDHTS_LABEL_UNEQUIPPED;
        labelMismatch_r <= 1'b0;
        labelUnequipped_r <= 1'b0;
    end
    else
    begin
        if (rxValid && rxKind == `SDHTS_KIND_LABEL)
        begin
            if (rxData != labelCand_r)
            begin
                labelCand_r <= rxData;
                labelCnt_r <= 3'h0;
            end
            // new candidate byte already counts as the first sighting
            else if (labelCnt_r == `SDHTS_LABEL_ACCEPT_FRAMES - 3'h2)
                acceptedLabel_r <= rxData;
            else
                labelCnt_r <= labelCnt_r + 3'h1;
        end
        labelUnequipped_r <= (acceptedLabel_r == `SDHTS_LABEL_UNEQUIPPED);
        labelMismatch_r <= !labelMatch &&
            (acceptedLabel_r != `SDHTS_LABEL_NON_SPECIFIC) &&
            (acceptedLabel_r != `SDHTS_LABEL_UNEQUIPPED);
    end
end

// ----------------------------------------------------------------------
// incoming alarm detection
// ----------------------------------------------------------------------
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        k2Cnt_r <= 3'h0;
        auCnt_r <= 3'h0;
        h1Ones_r <= 1'b0;
        msAisDefect_r <= 1'b0;
        auAlarmDefect_r <= 1'b0;
        tandemUnavailable_r <= 1'b0;
    end
    else
    begin
        if (rxValid && rxKind == `SDHTS_KIND_K2)
        begin
            k2Cnt_r <= persistNext(k2Cnt_r, k2Seen, msAisDefect_r);
            if (k2Seen != msAisDefect_r && k2Cnt_r == `SDHTS_AIS_PERSIST_FRAMES - 3'h1)
                msAisDefect_r <= k2Seen;
        end
        if (rxValid && rxKind == `SDHTS_KIND_H1)
            h1Ones_r <= (rxData == `SDHTS_ALL_ONES);
        if (rxValid && rxKind == `SDHTS_KIND_H2)
        begin
            auCnt_r <= persistNext(auCnt_r, auSeen, auAlarmDefect_r);
            if (auSeen != auAlarmDefect_r && auCnt_r == `SDHTS_AIS_PERSIST_FRAMES - 3'h1)
                auAlarmDefect_r <= auSeen;
        end
        tandemUnavailable_r <= pointerLossDefect || auAlarmDefect_r;
    end
end

// ----------------------------------------------------------------------
// sink output with all-ones insertion and remote defect
// ----------------------------------------------------------------------
always @(posedge mclk)
begin
    if (!rst_n)
    begin
        rxDataOut_r <= 8'h00;
        rxValidOut_r <= 1'b0;
        serverFailIndication_r <= 1'b0;
        farEndReceiveFailureBits_r <= 1'b0;
    end
    else
    begin
        rxValidOut_r <= rxValid;
        if (rxValid)
            rxDataOut_r <= sinkDefect ? `SDHTS_ALL_ONES : rxData;
        serverFailIndication_r <= sinkDefect;
        farEndReceiveFailureBits_r <= sinkDefect;
    end
end

// ----------------------------------------------------------------------
// source direction
// ----------------------------------------------------------------------
reg txAlarm;
reg txOnesHere;
reg [7:0] txNext;

always @*
begin
    txAlarm = txAllOnesIn || txServerFailIn;
    case (txLayerMode)
        `SDHTS_MODE_MS:
            txOnesHere = (txKind != `SDHTS_KIND_RSOH);
        `SDHTS_MODE_AU:
            txOnesHere = (txKind != `SDHTS_KIND_RSOH) &&
                (txKind != `SDHTS_KIND_MSOH) && (txKind != `SDHTS_KIND_K2);
        `SDHTS_MODE_TU:
            txOnesHere = (txKind == `SDHTS_KIND_TRIB);
        `SDHTS_MODE_PDH_LINE:
            txOnesHere = 1'b1;
        `SDHTS_MODE_PDH_TRIB:
            txOnesHere = (txKind == `SDHTS_KIND_TRIB);
        default:
            txOnesHere = 1'b0;
    endcase
    txNext = txData;
    if (txKind == `SDHTS_KIND_LABEL)
        txNext = transmittedLabel;
    else if (txKind == `SDHTS_KIND_REMOTE)
    begin
        txNext = 8'h00;
        txNext[`SDHTS_REMOTE_REI_MSB:`SDHTS_REMOTE_REI_LSB] =
            farEndBlockErrorBits_r[3:0];
        txNext[`SDHTS_REMOTE_RDI_BIT] = farEndReceiveFailureBits_r;
    end
    else if (txAlarm && txOnesHere)
        txNext = `SDHTS_ALL_ONES;
end

always @(posedge mclk)
begin
    if (!rst_n)
    begin
        txDataOut_r <= 8'h00;
        txValidOut_r <= 1'b0;
    end
    else
    begin
        txValidOut_r <= txValid;
        if (txValid)
            txDataOut_r <= txNext;
    end
end

endmodule

`default_nettype wire

//--- dv/sdhts_trail_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdhts_regs.vh"
// ----
// port checks
// ----
module sdhts_trail_properties #(
    parameter REI_WIDTH = 4,
    parameter ERR_COUNT_WIDTH = 16
) (
    input wire mclk,
    input wire rst_n,
    input wire [7:0] rxData,
    input wire rxValid,
    input wire [3:0] rxKind,
    input wire frameLossDefect,
    input wire [7:0] expectedLabel,
    input wire txValid,
    input wire [3:0] txKind,
    input wire [7:0] transmittedLabel,
    input wire [7:0] rxDataOut_r,
    input wire serverFailIndication_r,
    input wire msAisDefect_r,
    input wire auAlarmDefect_r,
    input wire [7:0] acceptedLabel_r,
    input wire labelMismatch_r,
    input wire labelUnequipped_r,
    input wire bitErrorPulse_r,
    input wire [ERR_COUNT_WIDTH-1:0] bitErrorCount_r,
    input wire farEndReceiveFailureBits_r,
    input wire [REI_WIDTH-1:0] farEndBlockErrorBits_r,
    input wire [7:0] txDataOut_r,
    input wire txValidOut_r
);
    wire k2Ones = rxValid && rxKind == `SDHTS_KIND_K2 && rxData[2:0] == `SDHTS_K2_AIS_CODE;
    wire h2Ones = rxValid && rxKind == `SDHTS_KIND_H2 && rxData == `SDHTS_ALL_ONES;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_txLabel;
        txValid && txKind == `SDHTS_KIND_LABEL;
    endsequence
    sequence s_lossHeld;
        frameLossDefect ##1 (frameLossDefect && rxValid);
    endsequence
    a_tx_label: assert property (s_txLabel |=> txValidOut_r &&
        txDataOut_r == $past(transmittedLabel)) else $error("tx label wrong");
    a_loss_ones: assert property (s_lossHeld |=> rxDataOut_r == 8'hff)
        else $error("no ones on loss");
    a_rdi_fail: assert property (farEndReceiveFailureBits_r ==
        $past(frameLossDefect || msAisDefect_r || auAlarmDefect_r) &&
        serverFailIndication_r == farEndReceiveFailureBits_r) else $error("rdi missing");
    a_mismatch_cause: assert property (labelMismatch_r |->
        $past(acceptedLabel_r) > 8'h01 && $past(acceptedLabel_r != expectedLabel))
        else $error("bad mismatch");
    a_uneq_flag: assert property ($past(rst_n) && $past(acceptedLabel_r) == 8'h00
        |-> labelUnequipped_r && !labelMismatch_r) else $error("unequipped wrong");
    a_err_pulse: assert property (bitErrorPulse_r |-> farEndBlockErrorBits_r != 0 &&
        $past(rxValid && rxKind == `SDHTS_KIND_BIP)) else $error("stray error pulse");
    a_err_count: assert property (bitErrorPulse_r |->
        bitErrorCount_r == $past(bitErrorCount_r) + farEndBlockErrorBits_r) else $error("count");
    a_k2_set: assert property ($rose(msAisDefect_r) |-> $past(k2Ones))
        else $error("section alarm cause");
    a_au_set: assert property ($rose(auAlarmDefect_r) |-> $past(h2Ones))
        else $error("au alarm cause");
endmodule
`default_nettype wire

//--- dv/sdhts_far_end.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdhts_regs.vh"
// ----
// far-end frame source
// ----
module sdhts_far_end (
    input wire mclk,
    output logic [7:0] rxData = 8'h00,
    output logic rxValid = 1'b0,
    output logic rxFrameStart = 1'b0,
    output logic [3:0] rxKind = 4'h0
);
    logic [7:0] curPar = 8'h00;
    logic [7:0] prevPar = 8'h00;
    logic [7:0] lastBip = 8'h00;
    task automatic put(input logic [3:0] kind, input logic [7:0] data, input logic start);
        @(posedge mclk);
        rxValid <= 1'b1;
        rxKind <= kind;
        rxData <= data;
        rxFrameStart <= start;
        curPar = curPar ^ data;
    endtask
    task automatic frame(input logic [7:0] lab, input logic [7:0] k2, input logic [7:0] ptr,
        input logic [7:0] flip);
        prevPar = curPar;
        curPar = 8'h00;
        put(`SDHTS_KIND_PAYLOAD, 8'h3c, 1'b1);
        put(`SDHTS_KIND_LABEL, lab, 1'b0);
        put(`SDHTS_KIND_K2, k2, 1'b0);
        put(`SDHTS_KIND_H1, ptr, 1'b0);
        put(`SDHTS_KIND_H2, ptr, 1'b0);
        lastBip = prevPar ^ flip;
        @(posedge mclk);
        rxKind <= `SDHTS_KIND_BIP;
        rxData <= lastBip;
        @(posedge mclk);
        rxValid <= 1'b0;
        rxData <= ~lastBip;
    endtask
endmodule
`default_nettype wire

//--- dv/sdhts_trail_supervision_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdhts_regs.vh"
// ----
// bench top
// ----
module sdhts_trail_supervision_tb;
    logic mclk, rst_n, frameLossDefect, pointerLossDefect, txValid, txAllOnesIn, txServerFailIn;
    logic [7:0] expectedLabel, txData, transmittedLabel;
    logic [3:0] txKind;
    logic [2:0] txLayerMode;
    wire [7:0] rxData, rxDataOut_r, acceptedLabel_r, txDataOut_r;
    wire [3:0] rxKind, farEndBlockErrorBits_r;
    wire [15:0] bitErrorCount_r;
    wire rxValid, rxFrameStart, rxValidOut_r, serverFailIndication_r, msAisDefect_r;
    wire auAlarmDefect_r, labelMismatch_r, labelUnequipped_r, bitErrorPulse_r;
    wire farEndReceiveFailureBits_r, tandemUnavailable_r, txValidOut_r;
    int miscompares = 0;
    int comparisons = 0;
    sdhts_trail_supervision u_dut (.mclk, .rst_n, .rxData, .rxValid, .rxFrameStart, .rxKind,
        .frameLossDefect, .pointerLossDefect, .expectedLabel, .txData, .txValid, .txKind,
        .txAllOnesIn, .txServerFailIn, .txLayerMode, .transmittedLabel, .rxDataOut_r,
        .rxValidOut_r, .serverFailIndication_r, .msAisDefect_r, .auAlarmDefect_r,
        .acceptedLabel_r, .labelMismatch_r, .labelUnequipped_r, .bitErrorPulse_r,
        .bitErrorCount_r, .farEndReceiveFailureBits_r, .farEndBlockErrorBits_r,
        .tandemUnavailable_r, .txDataOut_r, .txValidOut_r);
    sdhts_far_end u_far (.mclk, .rxData, .rxValid, .rxFrameStart, .rxKind);
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic tx(input logic [3:0] kind, input logic [7:0] exp);
        @(posedge mclk);
        txValid <= 1'b1;
        txKind <= kind;
        @(posedge mclk);
        #1;
        chk(txDataOut_r, exp);
    endtask
    task automatic t_label;
        logic [7:0] lab [4] = '{8'h13, 8'h01, 8'h22, 8'h00};
        for (int i = 0; i < 4; i++)
        begin
            repeat (5) u_far.frame(lab[i], 8'h00, 8'h00, 8'h00);
            #1;
            chk(acceptedLabel_r, lab[i]);
            chk(labelMismatch_r, i == 2);
            chk(labelUnequipped_r, i == 3);
            chk(bitErrorPulse_r, 1'b0);
        end
    endtask
    task automatic t_bip;
        logic [7:0] flips [2] = '{8'h05, 8'hff};
        logic [15:0] total [2] = '{16'h0002, 16'h000a};
        for (int i = 0; i < 2; i++)
        begin
            u_far.frame(8'h00, 8'h00, 8'h00, flips[i]);
            #1;
            chk(bitErrorPulse_r, 1'b1);
            chk(farEndBlockErrorBits_r, $countones(flips[i]));
            chk(bitErrorCount_r, total[i]);
        end
        tx(`SDHTS_KIND_REMOTE, 8'h80);
    endtask
    task automatic t_alarm;
        repeat (3) u_far.frame(8'h00, 8'h07, 8'h00, 8'h00);
        #1;
        chk(msAisDefect_r, 1'b1);
        chk(farEndReceiveFailureBits_r, 1'b1);
        chk(rxDataOut_r, 8'hff);
        chk(rxValidOut_r, 1'b1);
        tx(`SDHTS_KIND_REMOTE, 8'h08);
        repeat (3) u_far.frame(8'h00, 8'h00, 8'hff, 8'h00);
        #1;
        chk(msAisDefect_r, 1'b0);
        chk(auAlarmDefect_r, 1'b1);
        chk(tandemUnavailable_r, 1'b1);
        repeat (3) u_far.frame(8'h00, 8'h00, 8'h00, 8'h00);
        #1;
        chk(serverFailIndication_r, 1'b0);
        chk(rxDataOut_r, u_far.lastBip);
        @(posedge mclk);
        frameLossDefect <= 1'b1;
        pointerLossDefect <= 1'b1;
        u_far.frame(8'h00, 8'h00, 8'h00, 8'h00);
        #1;
        chk(rxDataOut_r, 8'hff);
        chk(tandemUnavailable_r, 1'b1);
        @(posedge mclk);
        frameLossDefect <= 1'b0;
        pointerLossDefect <= 1'b0;
    endtask
    task automatic t_tx;
        logic [15:0] masks [7] = '{16'hfffd, 16'hfff1, 16'h0200, 16'hffff, 16'h0200, 0, 0};
        logic [27:0] kinds = 28'h012379a;
        logic [3:0] k;
        logic [7:0] e;
        for (int m = 0; m < 7; m++)
        begin
            @(posedge mclk);
            txLayerMode <= m[2:0];
            txAllOnesIn <= m < 6 && !m[0];
            txServerFailIn <= m[0];
            for (int j = 0; j < 7; j++)
            begin
                k = kinds[4*j +: 4];
                e = masks[m][k] ? 8'hff : txData;
                if (k == `SDHTS_KIND_LABEL)
                    e = transmittedLabel;
                tx(k, e);
            end
        end
    endtask
    initial
    begin
        rst_n = 1'b0;
        {frameLossDefect, pointerLossDefect, txValid, txAllOnesIn, txServerFailIn} = 5'h00;
        expectedLabel = 8'h13;
        txData = 8'h5a;
        transmittedLabel = 8'h2b;
        txKind = 4'h0;
        txLayerMode = 3'h0;
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk(labelUnequipped_r, 1'b1);
        t_label();
        t_bip();
        t_alarm();
        t_tx();
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        close_out();
    end
endmodule
bind sdhts_trail_supervision sdhts_trail_properties #(.REI_WIDTH(REI_WIDTH),
    .ERR_COUNT_WIDTH(ERR_COUNT_WIDTH)) u_props (.mclk, .rst_n, .rxData, .rxValid, .rxKind,
    .frameLossDefect, .expectedLabel, .txValid, .txKind, .transmittedLabel, .rxDataOut_r,
    .serverFailIndication_r, .msAisDefect_r, .auAlarmDefect_r, .acceptedLabel_r,
    .labelMismatch_r, .labelUnequipped_r, .bitErrorPulse_r, .bitErrorCount_r,
    .farEndReceiveFailureBits_r, .farEndBlockErrorBits_r, .txDataOut_r, .txValidOut_r);
`default_nettype wire
